// ---- trace_readout_pkg.sv ----
// package for the trace buffer read-out: port offsets, widths, reset values
// assumes a single 20 MHz bus clock and plain ports, no register bus
package trace_readout_pkg;
  localparam int unsigned LINE_W = 64;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned WORDS_PER_LINE = 4;
  localparam int unsigned DEPTH = 64;
  localparam int unsigned LINE_AW = 6;
  localparam int unsigned WORD_SEL_W = 2;
  localparam logic [3:0] OFS_PORT_HIGH = 4'h0; // byte offset of high word
  localparam logic [3:0] OFS_PORT_LOW = 4'h2; // byte offset of low word
  localparam int unsigned TAG_RW_BIT = 1;
  localparam int unsigned TAG_OCF_BIT = 0;
  localparam logic [WORD_W-1:0] INVALID_DATA = 16'hffff;
  localparam logic [WORD_W-1:0] ZERO_DATA = 16'h0000;
  localparam logic [LINE_AW-1:0] PTR_RESET = 6'h00;
  localparam logic [WORD_SEL_W-1:0] WSEL_RESET = 2'h0;
  localparam logic [WORD_SEL_W-1:0] WSEL_LAST = 2'h3;
endpackage

// ---- trace_line_ram.sv ----
// trace line storage: one write port from the capture side, registered read
// assumes read address is held while the read data is used
`timescale 1ns/10ps
module trace_line_ram #(
  parameter int unsigned DW = 64,
  parameter int unsigned AW = 6
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array, only the read register matters
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// ---- trace_buffer_readout.sv ----
// trace buffer read-out: capture store, lock, read pointer and word order
// assumes port accesses are single-cycle strobes synchronous to i_clk
// assumes reads come at least two cycles after a pointer move, as ram data trail it
`timescale 1ns/10ps
module trace_buffer_readout #(
  parameter int unsigned DEPTH = trace_readout_pkg::DEPTH,
  parameter int unsigned AW = trace_readout_pkg::LINE_AW
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  // debug_trace_unit state
  input wire logic i_armed,
  input wire logic i_arm_write_one,
  input wire logic [1:0] i_trace_source_select,
  input wire logic i_secured,
  // capture side
  input wire logic i_cap_valid,
  input wire logic [trace_readout_pkg::LINE_W-1:0] i_cap_line,
  input wire logic i_cap_rw,
  input wire logic i_cap_opfetch,
  input wire logic i_session_start,
  // trace_buffer_port access
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic i_acc_word,
  input wire logic [3:0] i_acc_addr,
  output logic o_rd_valid,
  output logic [trace_readout_pkg::WORD_W-1:0] o_rd_data,
  // trace_count_register
  output logic [AW:0] o_valid_line_count,
  output logic o_locked,
  output logic [1:0] o_cur_tag
);
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW-1:0] nxt_rd_ptr;
  logic [trace_readout_pkg::WORD_SEL_W-1:0] wsel_ff;
  logic [trace_readout_pkg::WORD_SEL_W-1:0] nxt_wsel;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic overflow_ff;
  logic locked_ff;
  logic rd_valid_ff;
  logic [trace_readout_pkg::WORD_W-1:0] rd_data_ff;
  logic [1:0] tag_mem [0:DEPTH-1];
  logic [1:0] tag_ff;
  logic [trace_readout_pkg::LINE_W-1:0] ram_q;

  // access decode; the port sits in the lowest four bytes
  wire aligned = i_acc_word && (i_acc_addr[0] == 1'b0);
  wire on_port = (i_acc_addr[3:2] == trace_readout_pkg::OFS_PORT_HIGH[3:2]);
  wire port_wr = i_acc_valid && i_acc_write && aligned && on_port;
  wire high_wr = port_wr && (i_acc_addr == trace_readout_pkg::OFS_PORT_HIGH);
  wire port_rd = i_acc_valid && !i_acc_write && on_port;

  // unlock and rewind only count while disarmed; armed writes are ignored
  wire unlock_wr = port_wr && !i_armed;
  wire rewind = high_wr && !i_armed;

  // read permission; a locked, disarmed buffer answers zero rather than stale data
  wire sourced = |i_trace_source_select;
  wire permit = !i_armed && sourced && !i_secured && !locked_ff;
  wire good_rd = port_rd && aligned && permit;
  wire step_rd = good_rd || unlock_wr;

  // pointer helpers; both pointers wrap at the last line
  wire [AW-1:0] oldest = overflow_ff ? wr_ptr_ff : trace_readout_pkg::PTR_RESET;
  wire last_word = (wsel_ff == trace_readout_pkg::WSEL_LAST);
  wire capture = i_cap_valid && i_armed;
  wire wr_at_end = (wr_ptr_ff == AW'(DEPTH - 1));
  wire rd_at_end = (rd_ptr_ff == AW'(DEPTH - 1));

  // word select, low word first; all four words incl. invalid bytes
  wire [trace_readout_pkg::WORD_W-1:0] word_mux =
    ram_q[wsel_ff*trace_readout_pkg::WORD_W +: trace_readout_pkg::WORD_W];

  // read answer; misaligned beats armed, armed beats the permission check
  wire [trace_readout_pkg::WORD_W-1:0] refused_data = (aligned && i_armed) ?
    trace_readout_pkg::INVALID_DATA :
    trace_readout_pkg::ZERO_DATA;
  wire [trace_readout_pkg::WORD_W-1:0] nxt_rd_data = good_rd ? word_mux : refused_data;

  // write side next state; count saturates once every line is used
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_count = count_ff;
    if (capture) begin
      nxt_wr_ptr = wr_at_end ? '0 : wr_ptr_ff + 1'b1;
      if (count_ff != (AW+1)'(DEPTH)) begin
        nxt_count = count_ff + 1'b1;
      end
    end
    if (i_session_start) begin
      nxt_wr_ptr = trace_readout_pkg::PTR_RESET;
      nxt_count = '0;
    end
  end

  // read side next state; a rewind beats a step, arming pins the pointer
  always_comb begin
    nxt_rd_ptr = rd_ptr_ff;
    nxt_wsel = wsel_ff;
    if (rewind) begin
      nxt_rd_ptr = oldest;
      nxt_wsel = trace_readout_pkg::WSEL_RESET;
    end else if (step_rd) begin
      nxt_wsel = wsel_ff + 1'b1;
      if (last_word) begin
        nxt_rd_ptr = rd_at_end ? '0 : rd_ptr_ff + 1'b1;
      end
    end else if (i_armed) begin
      nxt_rd_ptr = nxt_count[AW] ? nxt_wr_ptr : trace_readout_pkg::PTR_RESET;
      nxt_wsel = trace_readout_pkg::WSEL_RESET;
    end
  end

  // line store; its read data trail the pointer by one cycle
  trace_line_ram #(
    .DW(trace_readout_pkg::LINE_W),
    .AW(AW)
  ) u_ram (
    .i_clk(i_clk),
    .i_we(capture),
    .i_waddr(wr_ptr_ff),
    .i_wdata(i_cap_line),
    .i_raddr(rd_ptr_ff),
    .o_rdata(ram_q)
  );

  // tag bits kept beside each line; the array itself needs no reset
  always_ff @(posedge i_clk) begin
    if (capture) begin
      tag_mem[wr_ptr_ff] <= {i_cap_rw, i_cap_opfetch};
    end
  end

  // tag of the line at the read pointer, cleared at reset; unwritten lines still show unknown
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tag_ff <= 2'h0;
    end else begin
      tag_ff <= tag_mem[rd_ptr_ff];
    end
  end

  // lock: set on arm, cleared by one aligned word write while disarmed
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      locked_ff <= 1'b0;
    end else if (i_arm_write_one) begin
      locked_ff <= 1'b1;
    end else if (unlock_wr) begin
      locked_ff <= 1'b0;
    end
  end

  // overflow marks that the write pointer wrapped
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      overflow_ff <= 1'b0;
    end else if (i_session_start) begin
      overflow_ff <= 1'b0;
    end else if (capture && wr_at_end) begin
      overflow_ff <= 1'b1;
    end
  end

  // write pointer; session start brings it back to line 0
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_ff <= trace_readout_pkg::PTR_RESET;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
    end
  end

  // read pointer and word select, moved only by reads, port writes and arming
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_ptr_ff <= trace_readout_pkg::PTR_RESET;
      wsel_ff <= trace_readout_pkg::WSEL_RESET;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
      wsel_ff <= nxt_wsel;
    end
  end

  // valid line count; no read path touches it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // read strobe, one cycle after every port read
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= port_rd;
    end
  end

  // read data hold until the next read, so a slow host can still take them
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_ff <= trace_readout_pkg::ZERO_DATA;
    end else if (port_rd) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // outputs come straight from flops
  assign o_rd_valid = rd_valid_ff;
  assign o_rd_data = rd_data_ff;
  assign o_valid_line_count = count_ff;
  assign o_locked = locked_ff;
  assign o_cur_tag = tag_ff;
endmodule

// ---- trace_readout_asserts.sv ----
// checker for the trace read-out port answers
// assumes it is bound onto trace_buffer_readout
`timescale 1ns/10ps
module trace_readout_asserts #(parameter int unsigned AW = 6) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_armed,
  input wire logic i_arm_write_one,
  input wire logic [1:0] i_trace_source_select,
  input wire logic i_secured,
  input wire logic i_session_start,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic i_acc_word,
  input wire logic [3:0] i_acc_addr,
  input wire logic o_rd_valid,
  input wire logic [15:0] o_rd_data,
  input wire logic [AW:0] o_valid_line_count,
  input wire logic o_locked
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // read strobes, aligned word reads of the port
  wire rd = i_acc_valid && !i_acc_write && i_acc_addr[3:2] == 2'h0;
  wire al = rd && i_acc_word && i_acc_addr[3:2] == 2'h0 && !i_acc_addr[0];
  rd_answer_a: assert property (rd |=> o_rd_valid) else $error("read not answered");
  byte_zero_a: assert property (rd && !i_acc_word |=> o_rd_data == 16'h0000)
    else $error("byte read not zero");
  odd_zero_a: assert property (rd && i_acc_addr[0] |=> o_rd_data == 16'h0000)
    else $error("misaligned read not zero");
  armed_invalid_a: assert property (al && i_armed && !o_locked |=> o_rd_data == 16'hffff)
    else $error("armed read not invalid");
  no_source_a: assert property (al && !i_armed && i_trace_source_select == 2'h0
    |=> o_rd_data == 16'h0000) else $error("read without source not zero");
  secured_zero_a: assert property (al && !i_armed && i_secured |=> o_rd_data == 16'h0000)
    else $error("secured read not zero");
  lock_set_a: assert property (i_arm_write_one |=> o_locked) else $error("lock not set");
  count_hold_a: assert property (rd && !i_armed && !i_session_start
    |=> $stable(o_valid_line_count)) else $error("count moved on read");
  // main scenarios reached
  cover property (al && !i_armed && !o_locked);
  cover property ($fell(o_locked));
  cover property (al && i_armed);
  cover property (o_valid_line_count[AW]);
endmodule
bind trace_buffer_readout trace_readout_asserts #(.AW(AW)) i_asserts (.*);

// ---- trace_host_model.sv ----
// host model: issues port accesses and takes the read data
// assumes o_rd_data holds until the next read
`timescale 1ns/10ps
module trace_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rd_data,
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic o_acc_word,
  output logic [3:0] o_acc_addr
);
  initial {o_acc_valid, o_acc_write, o_acc_word, o_acc_addr} = 7'h00;
  // req is {write, word, addr}; one strobe only, spare cycle lets ram settle
  task automatic access(input logic [5:0] req, output logic [15:0] dat);
    @(posedge i_clk);
    {o_acc_valid, o_acc_write, o_acc_word, o_acc_addr} <= {1'b1, req};
    @(posedge i_clk);
    o_acc_valid <= 1'b0;
    o_acc_addr <= ~req[3:0]; // released address must not look held
    @(posedge i_clk);
    dat = i_rd_data;
  endtask
endmodule

// ---- testbench.sv ----
// testbench: captures two lines, reads them back through the port
// assumes the host model drives the port, the bench the rest
`timescale 1ns/10ps
module testbench;
  logic i_clk, i_resetn, i_armed, i_arm_write_one, i_secured, i_cap_valid, i_cap_rw;
  logic i_cap_opfetch, i_session_start, i_acc_valid, i_acc_write, i_acc_word, o_rd_valid, o_locked;
  logic [1:0] i_trace_source_select, o_cur_tag;
  logic [63:0] i_cap_line;
  logic [3:0] i_acc_addr;
  logic [15:0] o_rd_data, d;
  logic [6:0] o_valid_line_count;
  int errors = 0;
  int check_count = 0;
  logic [15:0] rd_seen = 16'h0;
  localparam logic [63:0] l0 = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] l1 = 64'hfedc_ba98_7654_3210;
  trace_buffer_readout i_dut (.*);
  trace_host_model i_host (.i_clk(i_clk), .i_rd_data(o_rd_data), .o_acc_valid(i_acc_valid),
    .o_acc_write(i_acc_write), .o_acc_word(i_acc_word), .o_acc_addr(i_acc_addr));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // sel is {session start, arm write, capture valid}
  task automatic pulse(input logic [2:0] sel);
    @(posedge i_clk);
    {i_session_start, i_arm_write_one, i_cap_valid} <= sel;
    @(posedge i_clk);
    {i_session_start, i_arm_write_one, i_cap_valid} <= 3'h0;
  endtask
  // counts read answers as the host would see them
  always @(posedge i_clk) begin
    if (o_rd_valid === 1'b1) begin
      rd_seen <= rd_seen + 16'h1;
    end
  end
  // arm and capture two tagged lines, then unlock
  task automatic t_capture();
    i_armed <= 1'b1;
    pulse(3'h4);
    pulse(3'h2);
    {i_cap_rw, i_cap_opfetch, i_cap_line} <= {2'h2, l0};
    pulse(3'h1);
    {i_cap_rw, i_cap_opfetch, i_cap_line} <= {2'h1, l1};
    pulse(3'h1);
    i_armed <= 1'b0;
    @(negedge i_clk);
    chk("locked", {15'h0, o_locked}, 16'h1);
    chk("count", {9'h0, o_valid_line_count}, 16'h2);
    i_host.access(6'h12, d);
    chk("locked read", d, 16'h0);
    i_host.access(6'h30, d);
    @(negedge i_clk);
    chk("unlocked", {15'h0, o_locked}, 16'h0);
    $display("test capture done");
  endtask
  // words come out low first, line after line, count untouched
  task automatic t_order();
    chk("tag line0", {14'h0, o_cur_tag}, 16'h2);
    for (int k = 0; k < 4; k++) begin
      i_host.access(6'h12, d);
      chk("line0 word", d, l0[16*k +: 16]);
    end
    i_host.access(6'h12, d);
    chk("line1 word0", d, l1[15:0]);
    @(negedge i_clk);
    chk("tag line1", {14'h0, o_cur_tag}, 16'h1);
    chk("count held", {9'h0, o_valid_line_count}, 16'h2);
    $display("test order done");
  endtask
  // refused reads give their codes and leave the pointer alone
  task automatic t_refuse();
    i_host.access(6'h02, d);
    chk("byte read", d, 16'h0);
    i_host.access(6'h13, d);
    chk("odd read", d, 16'h0);
    i_trace_source_select <= 2'h0;
    i_host.access(6'h12, d);
    chk("no source", d, 16'h0);
    {i_trace_source_select, i_secured} <= 3'h3;
    i_host.access(6'h12, d);
    chk("secured", d, 16'h0);
    i_secured <= 1'b0;
    i_host.access(6'h12, d);
    chk("no move", d, l1[31:16]);
    i_host.access(6'h30, d);
    i_host.access(6'h12, d);
    chk("rewound", d, l0[15:0]);
    i_armed <= 1'b1;
    i_host.access(6'h12, d);
    chk("armed read", d, 16'hffff);
    i_armed <= 1'b0;
    $display("test refuse done");
  endtask
  // wrap the store once; the oldest line is the one after the newest
  task automatic t_overflow();
    pulse(3'h4);
    i_armed <= 1'b1;
    pulse(3'h2);
    for (int n = 0; n <= 64; n++) begin
      i_cap_line <= 64'(n);
      pulse(3'h1);
    end
    i_armed <= 1'b0;
    @(negedge i_clk);
    chk("full count", {9'h0, o_valid_line_count}, 16'h40);
    i_host.access(6'h30, d);
    for (int k = 0; k < 5; k++) begin
      i_host.access(6'h12, d);
      chk("oldest word", d, (k == 0) ? 16'h1 : ((k == 4) ? 16'h2 : 16'h0));
    end
    @(negedge i_clk);
    chk("read answers", rd_seen, 16'h12);
    $display("test overflow done");
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    #(3000 * 50);
    errors++;
    finish_test();
  end
  initial begin
    {i_resetn, i_armed, i_arm_write_one, i_secured, i_cap_valid, i_session_start} = 6'h00;
    {i_cap_rw, i_cap_opfetch, i_cap_line, i_trace_source_select} = 68'h1;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_capture();
    t_order();
    t_refuse();
    t_overflow();
    finish_test();
  end
endmodule
